// ### bench/pbsa_ctrl_model.sv
`timescale 1ns/100ps
// ****************************************************************
// controller model: one bus operation per qualified edge
// ****************************************************************
module pbsa_ctrl_model (
    input  wire logic                        clk_i,
    output logic                             cq_n_o,
    output logic                             cs1_n_o,
    output logic                             cs2_o,
    output logic                             cs3_n_o,
    output logic                             adv_o,
    output logic                             we_n_o,
    output logic [pbsa_pkg::LANES-1:0]       lane_n_o,
    output logic                             oe_n_o,
    output logic [pbsa_pkg::ADDR_W-1:0]      addr_o,
    output logic [pbsa_pkg::DATA_W-1:0]      dq_o,
    output logic [pbsa_pkg::LANES-1:0]       par_o
);
    import pbsa_pkg::*;

    logic              act;
    logic              btyp;
    logic [1:0]        wv;
    logic [DATA_W-1:0] wd [2];
    logic [LANES-1:0]  wp [2];

    // bus idles as a deselect
    initial
    begin
        cq_n_o  = 1'b0;
        cs1_n_o = 1'b1;
        cs2_o   = 1'b0;
        cs3_n_o = 1'b1;
        adv_o   = 1'b0;
        we_n_o  = 1'b1;
        lane_n_o = 4'hF;
        oe_n_o  = 1'b0;
        addr_o  = 8'h00;
        dq_o    = 32'h0;
        par_o   = 4'h0;
        act     = 1'b0;
        btyp    = 1'b0;
        wv      = 2'h0;
    end

    // advance beats show junk on the pins the device must ignore
    task automatic issue(input logic ld, input logic sel, input logic wr, input logic [ADDR_W-1:0] a,
                         input logic [LANES-1:0] lane_wr_n, input logic [DATA_W-1:0] d,
                         input logic [LANES-1:0] p, input logic oe_n);
        @(posedge clk_i);
        if (ld)
        begin
            act  = sel;
            btyp = wr;
        end
        cq_n_o   <= 1'b0;
        adv_o    <= ~ld;
        cs1_n_o  <= ~(ld & sel);
        cs2_o    <= ld & sel;
        cs3_n_o  <= ~(ld & sel);
        we_n_o   <= ld ? ~wr : btyp;
        lane_n_o <= lane_wr_n;
        oe_n_o   <= oe_n;
        addr_o  <= ld ? a : ~a;
        // released bus never repeats its last value
        if (wv[1])
        begin
            dq_o  <= wd[1];
            par_o <= wp[1];
        end
        else
        begin
            dq_o  <= ~dq_o;
            par_o <= ~par_o;
        end
        wv[1] = wv[0];
        wd[1] = wd[0];
        wp[1] = wp[0];
        wv[0] = act & btyp;
        wd[0] = d;
        wp[0] = p;
    endtask

    // one unqualified edge; every other pin holds
    task automatic hold();
        @(posedge clk_i);
        cq_n_o <= 1'b1;
    endtask
endmodule

// ### bench/pipelined_burst_sram_access_tb.sv
`timescale 1ns/100ps
module pipelined_burst_sram_access_tb;
    import pbsa_pkg::*;

    // ****************************************************************
    // signals and reference
    // ****************************************************************
    logic              ref_clk = 1'b0;
    logic              rst     = 1'b1;
    logic              mode    = 1'b0;
    logic              sleep   = 1'b0;
    logic              oe_n    = 1'b0;
    logic              cq_n, cs1_n, cs2, cs3_n, adv, we_n, rd_oe, wr_rdy, slp, rd_en_n;
    logic [LANES-1:0]  lane_n, par_w, rd_par;
    logic [ADDR_W-1:0] addr, base;
    logic [DATA_W-1:0] dq_w, rd_dq;
    logic [DATA_W-1:0] mem_d [MEM_DEPTH];
    logic [LANES-1:0]  mem_p [MEM_DEPTH];
    logic [1:0]        beat;
    logic [7:0]        gen     = 8'h00;
    logic              act, typ;
    logic [1:0]        pv      = 2'h0;
    logic [35:0]       pe [2];
    int                err_total = 0;
    int                n_tests   = 0;

    always #2.5 ref_clk = ~ref_clk;

    pbsa_ctrl_model u_ctrl (.clk_i(ref_clk), .cq_n_o(cq_n), .cs1_n_o(cs1_n), .cs2_o(cs2), .cs3_n_o(cs3_n),
                            .adv_o(adv), .we_n_o(we_n), .lane_n_o(lane_n), .oe_n_o(rd_en_n), .addr_o(addr),
                            .dq_o(dq_w), .par_o(par_w));

    pbsa_sram_core u_dut (.ref_clk_i(ref_clk), .rst_i(rst), .clock_qualify_n_i(cq_n),
                          .chip_select_first_n_i(cs1_n), .chip_select_second_i(cs2),
                          .chip_select_third_n_i(cs3_n), .advance_or_load_i(adv), .write_enable_n_i(we_n),
                          .byte_lane_write_n_i(lane_n), .output_enable_n_i(rd_en_n), .addr_i(addr),
                          .burst_order_i(mode), .sleep_request_i(sleep), .dq_i(dq_w), .parity_io_i(par_w),
                          .dq_o(rd_dq), .parity_io_o(rd_par), .dq_oe_o(rd_oe), .write_ready_o(wr_rdy),
                          .sleep_active_o(slp));

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        if (err_total == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // one bus op; checks the op issued two calls before
    task automatic op(input logic ld, input logic sel, input logic wr, input logic [ADDR_W-1:0] a,
                      input logic [LANES-1:0] bn);
        logic [ADDR_W-1:0] ba;
        logic [DATA_W-1:0] d;
        logic [LANES-1:0]  p;
        if (ld)
        begin
            base = a;
            beat = 2'h0;
            act  = sel;
            typ  = wr;
        end
        else
            beat = beat + 2'h1;
        ba  = {base[7:2], mode ? base[1:0] ^ beat : base[1:0] + beat};
        gen = gen + 8'h01;
        d   = {ba, ~ba, ba ^ gen, gen};
        p   = gen[3:0];
        for (int l = 0; l < LANES; l++)
        begin
            if (act && typ && !bn[l])
            begin
                mem_d[ba][l*BYTE_W +: BYTE_W] = d[l*BYTE_W +: BYTE_W];
                mem_p[ba][l] = p[l];
            end
        end
        u_ctrl.issue(ld, sel, wr, a, bn, d, p, oe_n);
        #1;
        if (pv[1])
            chk({rd_par, rd_dq}, pe[1]);
        chk(36'(rd_oe), 36'(pv[1]));
        // enable for the older op is sampled at this op's edge
        pv[1] = pv[0] & ~oe_n;
        pe[1] = pe[0];
        pv[0] = act & ~typ;
        pe[0] = {mem_p[ba], mem_d[ba]};
    endtask

    task automatic burst(input logic wr, input logic [ADDR_W-1:0] a, input int n, input logic [LANES-1:0] bn);
        op(1'b1, 1'b1, wr, a, bn);
        for (int i = 1; i < n; i++)
            op(1'b0, 1'b0, 1'b0, a, bn);
    endtask

    task automatic idle(input int n);
        repeat (n) op(1'b1, 1'b0, 1'b0, 8'h00, 4'hF);
    endtask

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial
    begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        chk({rd_par, rd_dq}, 36'h0);
        chk(36'(rd_oe), 36'h0);
        chk(36'(slp), 36'h0);
        chk(36'(wr_rdy), 36'h0);
        // linear bursts; the read wraps past its fourth beat
        burst(1'b1, 8'h42, 4, 4'h0);
        chk(36'(wr_rdy), 36'h1);
        idle(2);
        burst(1'b0, 8'h42, 6, 4'h0);
        // back to back write and read, then a byte write
        burst(1'b1, 8'h10, 1, 4'h0);
        burst(1'b0, 8'h43, 1, 4'h0);
        burst(1'b1, 8'h42, 1, 4'hA);
        idle(4);
        burst(1'b0, 8'h42, 1, 4'hF);
        // enable high on both beats keeps the bus released for the first beat only
        oe_n = 1'b1;
        burst(1'b0, 8'h41, 2, 4'hF);
        oe_n = 1'b0;
        idle(2);
        // frozen edges right after a read is latched
        burst(1'b0, 8'h43, 1, 4'hF);
        repeat (3)
        begin
            u_ctrl.hold();
            #1;
            chk(36'(rd_oe), 36'h0);
        end
        idle(2);
        // interleaved order
        @(posedge ref_clk);
        mode <= 1'b1;
        burst(1'b1, 8'h81, 4, 4'h0);
        idle(2);
        burst(1'b0, 8'h81, 4, 4'h0);
        idle(2);
        // sleep keeps the array contents
        @(posedge ref_clk);
        sleep <= 1'b1;
        idle(3);
        chk(36'(slp), 36'h1);
        @(posedge ref_clk);
        sleep <= 1'b0;
        idle(3);
        chk(36'(slp), 36'h0);
        burst(1'b0, 8'h83, 1, 4'hF);
        idle(2);
        end_of_test();
    end

    // watchdog, well beyond the sequence length
    initial
    begin
        repeat (1000) @(posedge ref_clk);
        err_total++;
        end_of_test();
    end
endmodule

// ### hdl/pbsa_fifo.sv
`timescale 1ns/100ps
module pbsa_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             en_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    import pbsa_pkg::*;

    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

    logic [WIDTH-1:0] store_q [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] wr_ptr_d;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [PTR_W-1:0] rd_ptr_d;
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    logic             push;
    logic             pop;

    // ****************************************************************
    // flags and handshakes
    // ****************************************************************
    assign in_ready_o  = (count_q != CNT_FULL);
    assign out_valid_o = (count_q != '0);
    assign out_data_o  = store_q[rd_ptr_q];
    assign push        = en_i && in_valid_i && in_ready_o;
    assign pop         = en_i && out_valid_o && out_ready_i;

    // pointer wrap is explicit so depth need not be a power of two
    always_comb
    begin
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        count_d  = count_q;
        if (push)
        begin
            wr_ptr_d = (wr_ptr_q == PTR_LAST) ? '0 : PTR_W'(wr_ptr_q + 1'b1);
        end
        if (pop)
        begin
            rd_ptr_d = (rd_ptr_q == PTR_LAST) ? '0 : PTR_W'(rd_ptr_q + 1'b1);
        end
        if (push && !pop)
        begin
            count_d = CNT_W'(count_q + 1'b1);
        end
        else if (pop && !push)
        begin
            count_d = CNT_W'(count_q - 1'b1);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end
        else
        begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q  <= count_d;
        end
    end

    // storage needs no reset; count guards stale words
    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            store_q[wr_ptr_q] <= in_data_i;
        end
    end

endmodule

// ### hdl/pbsa_pkg.sv
package pbsa_pkg;

    // ****************************************************************
    // sizes, timing and encodings
    // ****************************************************************
    localparam int ADDR_W        = 8;
    localparam int MEM_DEPTH     = 1 << ADDR_W;
    localparam int LANES         = 4;
    localparam int BYTE_W        = 8;
    localparam int LANE_W        = BYTE_W + 1;
    localparam int DATA_W        = LANES * BYTE_W;
    localparam int FIFO_DEPTH    = 8;
    localparam int CLK_PERIOD_NS = 5;
    localparam int SLEEP_NS      = 2 * CLK_PERIOD_NS;
    // entry into sleep takes two cycles; SLEEP_NS rounded up to whole cycles
    localparam int SLEEP_CYCLES  = (SLEEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] BEAT_FIRST = 2'h0;
    localparam logic [1:0] BEAT_STEP  = 2'h1;
    localparam logic       ORDER_LINEAR = 1'b0;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef logic [LANES-1:0][LANE_W-1:0] pbsa_word_t;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_READ,
        PH_WRITE
    } pbsa_phase_t;

    typedef struct packed {
        pbsa_phase_t       kind;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0]  lane_en;
    } pbsa_op_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0]  lane_en;
        pbsa_word_t        data;
    } pbsa_wr_t;

    localparam int WR_W = $bits(pbsa_wr_t);

    // ****************************************************************
    // helpers
    // ****************************************************************
    // low address bits of a burst beat, linear or interleaved
    function automatic logic [1:0] pbsa_burst_lo(input logic [1:0] start,
                                                 input logic [1:0] beat,
                                                 input logic       interleave);
        return interleave ? (start ^ beat) : 2'(start + beat);
    endfunction

    // parity bit rides on top of its byte in each lane
    function automatic pbsa_word_t pbsa_pack(input logic [DATA_W-1:0] dq,
                                             input logic [LANES-1:0]  par);
        pbsa_word_t w;
        for (int l = 0; l < LANES; l++)
        begin
            w[l] = {par[l], dq[l*BYTE_W +: BYTE_W]};
        end
        return w;
    endfunction

endpackage

// ### hdl/pbsa_sram_core.sv
`timescale 1ns/100ps
module pbsa_sram_core (
    input  wire logic                          ref_clk_i,
    input  wire logic                          rst_i,
    input  wire logic                          clock_qualify_n_i,
    input  wire logic                          chip_select_first_n_i,
    input  wire logic                          chip_select_second_i,
    input  wire logic                          chip_select_third_n_i,
    input  wire logic                          advance_or_load_i,
    input  wire logic                          write_enable_n_i,
    input  wire logic [pbsa_pkg::LANES-1:0]    byte_lane_write_n_i,
    input  wire logic                          output_enable_n_i,
    input  wire logic [pbsa_pkg::ADDR_W-1:0]   addr_i,
    input  wire logic                          burst_order_i,
    input  wire logic                          sleep_request_i,
    input  wire logic [pbsa_pkg::DATA_W-1:0]   dq_i,
    input  wire logic [pbsa_pkg::LANES-1:0]    parity_io_i,
    output logic      [pbsa_pkg::DATA_W-1:0]   dq_o,
    output logic      [pbsa_pkg::LANES-1:0]    parity_io_o,
    output logic                               dq_oe_o,
    output logic                               write_ready_o,
    output logic                               sleep_active_o
);
    import pbsa_pkg::*;

    // ****************************************************************
    // declarations
    // ****************************************************************
    pbsa_word_t        mem_q [MEM_DEPTH];
    pbsa_op_t          op1_q;
    pbsa_op_t          op1_d;
    pbsa_op_t          op2_q;
    pbsa_op_t          op2_d;
    logic [ADDR_W-1:0] base_q;
    logic [ADDR_W-1:0] base_d;
    logic [1:0]        cnt_q;
    logic [1:0]        cnt_d;
    logic              mode_q;
    logic              mode_d;
    logic [SLEEP_CYCLES-1:0] sleep_pipe_q;
    logic [SLEEP_CYCLES-1:0] sleep_pipe_d;
    pbsa_word_t        dout_q;
    pbsa_word_t        dout_d;
    logic              drive_q;
    logic              drive_d;
    logic              push_q;
    logic              push_d;
    pbsa_wr_t          push_data_q;
    pbsa_wr_t          push_data_d;
    logic              wready_q;
    logic              wready_d;
    logic              ce;
    logic              sel;
    logic              asleep;
    logic              fifo_in_ready;
    logic              fifo_out_valid;
    logic [WR_W-1:0]   fifo_out_bits;
    pbsa_wr_t          drain;
    logic              mem_we;
    pbsa_word_t        rd_word;

    assign ce     = !clock_qualify_n_i;
    assign sel    = !chip_select_first_n_i && chip_select_second_i && !chip_select_third_n_i;
    assign asleep = sleep_pipe_q[SLEEP_CYCLES-1];
    assign rd_word = mem_q[op1_q.addr];
    assign drain  = pbsa_wr_t'(fifo_out_bits);
    // the array is idle in sleep, so posted writes wait in the buffer
    assign mem_we = ce && fifo_out_valid && !asleep;

    // ****************************************************************
    // access pipeline: next values
    // ****************************************************************
    always_comb
    begin
        op1_d        = op1_q;
        op2_d        = op2_q;
        base_d       = base_q;
        cnt_d        = cnt_q;
        mode_d       = mode_q;
        sleep_pipe_d = sleep_pipe_q;
        dout_d       = dout_q;
        drive_d      = drive_q;
        push_d       = push_q;
        push_data_d  = push_data_q;
        wready_d     = wready_q;
        if (ce)
        begin
            // strap is re-sampled each qualified edge; it must not move in use
            mode_d       = burst_order_i;
            sleep_pipe_d = {sleep_pipe_q[SLEEP_CYCLES-2:0], sleep_request_i};
            op2_d        = op1_q;
            wready_d     = fifo_in_ready;
            op1_d.lane_en = ~byte_lane_write_n_i;
            if (!advance_or_load_i)
            begin
                if (sel && !asleep)
                begin
                    op1_d.kind = write_enable_n_i ? PH_READ : PH_WRITE;
                    op1_d.addr = addr_i;
                    base_d     = addr_i;
                    cnt_d      = BEAT_FIRST;
                end
                else
                begin
                    op1_d.kind = PH_IDLE;
                end
            end
            else if (op1_q.kind != PH_IDLE)
            begin
                // selects and write strobe are not looked at here
                cnt_d      = 2'(cnt_q + BEAT_STEP);
                op1_d.addr = {base_q[ADDR_W-1:2],
                              pbsa_burst_lo(base_q[1:0], cnt_d, mode_q)};
            end
            if (asleep)
            begin
                op1_d.kind = PH_IDLE;
            end
            // read data moves through the output register one edge on
            if (op1_q.kind == PH_READ)
            begin
                dout_d = rd_word;
            end
            // no drive in write data phase, after deselect, or oe high
            drive_d = (op1_q.kind == PH_READ) && !output_enable_n_i;
            // write data sampled two edges after its address
            push_d           = (op2_q.kind == PH_WRITE);
            push_data_d.addr = op2_q.addr;
            push_data_d.lane_en = op2_q.lane_en;
            push_data_d.data = pbsa_pack(dq_i, parity_io_i);
        end
    end

    // ****************************************************************
    // access pipeline: registers
    // ****************************************************************
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            op1_q        <= '{kind: PH_IDLE, addr: '0, lane_en: '0};
            op2_q        <= '{kind: PH_IDLE, addr: '0, lane_en: '0};
            base_q       <= '0;
            cnt_q        <= BEAT_FIRST;
            mode_q       <= ORDER_LINEAR;
            sleep_pipe_q <= '0;
            dout_q       <= '0;
            drive_q      <= 1'b0;
            push_q       <= 1'b0;
            push_data_q  <= '0;
            wready_q     <= 1'b0;
        end
        else
        begin
            op1_q        <= op1_d;
            op2_q        <= op2_d;
            base_q       <= base_d;
            cnt_q        <= cnt_d;
            mode_q       <= mode_d;
            sleep_pipe_q <= sleep_pipe_d;
            dout_q       <= dout_d;
            drive_q      <= drive_d;
            push_q       <= push_d;
            push_data_q  <= push_data_d;
            wready_q     <= wready_d;
        end
    end

    // ****************************************************************
    // posted write buffer and storage array
    // ****************************************************************
    pbsa_fifo #(
        .WIDTH (WR_W),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_i       (ref_clk_i),
        .rst_i       (rst_i),
        .en_i        (ce),
        .in_valid_i  (push_q),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (push_data_q),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (!asleep),
        .out_data_o  (fifo_out_bits)
    );

    // per-lane enables keep unselected bytes untouched
    always_ff @(posedge ref_clk_i)
    begin
        if (mem_we)
        begin
            for (int l = 0; l < LANES; l++)
            begin
                if (drain.lane_en[l])
                begin
                    mem_q[drain.addr][l] <= drain.data[l];
                end
            end
        end
    end

    // ****************************************************************
    // outputs, all straight from flip-flops
    // ****************************************************************
    always_comb
    begin
        for (int l = 0; l < LANES; l++)
        begin
            dq_o[l*BYTE_W +: BYTE_W] = dout_q[l][BYTE_W-1:0];
            parity_io_o[l]           = dout_q[l][BYTE_W];
        end
    end
    assign dq_oe_o        = drive_q;
    assign write_ready_o  = wready_q;
    assign sleep_active_o = sleep_pipe_q[SLEEP_CYCLES-1];

    // ****************************************************************
    // assertions
    // ****************************************************************
    sequence s_load;
        ce && !advance_or_load_i && sel && !asleep;
    endsequence

    sequence s_rd_load;
        s_load and write_enable_n_i;
    endsequence

    sequence s_wr_load;
        s_load and !write_enable_n_i;
    endsequence

    sequence s_beat;
        ce && advance_or_load_i && (op1_q.kind != PH_IDLE) && !asleep;
    endsequence

    a_freeze_state: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !ce |=> $stable(dq_o) && $stable(dq_oe_o) && $stable(op1_q) && $stable(cnt_q))
        else $error("state moved while clock qualify was high");

    a_addr_latch: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_load |=> (op1_q.addr == $past(addr_i)) && (op1_q.kind != PH_IDLE))
        else $error("address not latched on load");

    a_read_drive: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_rd_load ##1 (ce && !output_enable_n_i) |=> dq_oe_o)
        else $error("read data not driven one edge after latch");

    a_oe_mask: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ce && output_enable_n_i |=> !dq_oe_o)
        else $error("outputs driven with output enable high");

    a_write_float: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_wr_load ##1 ce |=> !dq_oe_o)
        else $error("outputs driven during write data phase");

    a_deselect_pipe: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (ce && !advance_or_load_i && !sel) ##1 ce |=> !dq_oe_o)
        else $error("outputs driven after deselect");

    a_burst_step: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_beat |=> (cnt_q == 2'($past(cnt_q) + BEAT_STEP)) &&
                   (op1_q.addr[1:0] == pbsa_burst_lo(base_q[1:0], cnt_q, $past(mode_q))) &&
                   (op1_q.addr[ADDR_W-1:2] == base_q[ADDR_W-1:2]))
        else $error("burst address step wrong");

    a_type_held: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_beat |=> op1_q.kind == $past(op1_q.kind))
        else $error("access type changed inside a burst");

    a_write_take: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_wr_load ##1 ce ##1 ce |=> push_q &&
            (push_data_q.data == pbsa_pack($past(dq_i), $past(parity_io_i))))
        else $error("write data not taken two edges after address");

    a_sleep_entry: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (ce && sleep_request_i) [*2] |=> sleep_active_o)
        else $error("sleep not entered after two edges");

    a_sleep_still: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ce && sleep_active_o |=> op1_q.kind == PH_IDLE)
        else $error("access accepted while asleep");

endmodule
